// [common/bkm_pkg.sv]
// shared constants and types for the breakpoint range matcher
//
// Summary of operation
// - breakpoint covers 1, 2, 4 or 8 bytes
// - two-byte word aligned, four-byte doubleword aligned
// - length field masks low stored address bits
// - io port address zero-extended before compare
// - data hit when any accessed byte overlaps
// - code hit only on instruction first byte
// - all six debug registers are 64 bits
// - outside 64-bit mode, upper half zeroed
// - 64-bit mode moves full 64 bits
// - reserved upper status/control bits fault when set in 64-bit mode
// - address registers fully writable, no range check
// - eight-byte data ranges work in every mode
// - length 00=1, 01=2, 11=4, 10=8 bytes
// - type 00 exec, 01 write, 10 io, 11 rw
package bkm_pkg;

  // ---------------------------------------------------------------
  // register move selectors
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_ADDR_3 = 3'h3;
  localparam logic [2:0] SEL_ALIAS_STATUS = 3'h4;
  localparam logic [2:0] SEL_ALIAS_CTRL = 3'h5;
  localparam logic [2:0] SEL_STATUS = 3'h6;
  localparam logic [2:0] SEL_CTRL = 3'h7;
  localparam logic [2:0] SEL_ALIAS_OFFSET = 3'h2;

  // ---------------------------------------------------------------
  // widths and field layout of the control register
  // ---------------------------------------------------------------
  localparam int NUM_BP = 4;
  localparam int REG_W = 64;
  localparam int HALF_W = 32;
  localparam int PORT_W = 16;
  localparam int CTRL_RW_LSB = 16;
  localparam int CTRL_LEN_LSB = 18;
  localparam int CTRL_FIELD_STRIDE = 4;
  localparam int CTRL_ENABLE_STRIDE = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [63:0] ADDR_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] STATUS_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] CTRL_RESET = 64'h0000_0000_0000_0000;
  localparam logic [31:0] UPPER_ZERO = 32'h0000_0000;
  localparam logic [47:0] PORT_EXT_ZERO = 48'h0000_0000_0000;

  // ---------------------------------------------------------------
  // length field codes and the matching last-byte offsets
  // ---------------------------------------------------------------
  localparam logic [1:0] LEN_1B = 2'h0;
  localparam logic [1:0] LEN_2B = 2'h1;
  localparam logic [1:0] LEN_8B = 2'h2;
  localparam logic [1:0] LEN_4B = 2'h3;
  localparam logic [2:0] SPAN_1B = 3'h0;
  localparam logic [2:0] SPAN_2B = 3'h1;
  localparam logic [2:0] SPAN_4B = 3'h3;
  localparam logic [2:0] SPAN_8B = 3'h7;
  localparam logic [60:0] SPAN_PAD = 61'h0;

  // ---------------------------------------------------------------
  // access type field codes
  // ---------------------------------------------------------------
  localparam logic [1:0] RW_EXEC = 2'h0;
  localparam logic [1:0] RW_WRITE = 2'h1;
  localparam logic [1:0] RW_IO = 2'h2;
  localparam logic [1:0] RW_DATA = 2'h3;

  // kind of access presented by the core
  typedef enum logic [1:0] {
    ACC_FETCH,
    ACC_READ,
    ACC_WRITE,
    ACC_IO
  } bkm_kind_t;

  // one memory, fetch or io access; span is byte count minus one
  typedef struct packed {
    logic valid;
    bkm_kind_t kind;
    logic [63:0] addr;
    logic [2:0] span;
  } bkm_access_t;

  // one debug register move
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] sel;
    logic [63:0] wdata;
  } bkm_move_t;

endpackage

// [rtl/bkm_matcher.sv]
// debug register file and four-way breakpoint range matcher
`timescale 1ns/100ps
module bkm_matcher
  import bkm_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic MODE64_I,
  input wire logic DEBUG_EXT_I,
  input wire bkm_pkg::bkm_move_t MOVE_I,
  input wire bkm_pkg::bkm_access_t ACC_I,
  output logic [63:0] RDATA_O,
  output logic RVALID_O,
  output logic GP_FAULT_O,
  output logic [3:0] HIT_VEC_O,
  output logic BRK_ENABLED_HIT_O
);

  import bkm_pkg::*;

  logic [3:0][63:0] bp_addr_reg;
  logic [63:0] debug_status_reg;
  logic [63:0] status_next;
  logic [63:0] debug_control_reg;
  logic [63:0] rdata_reg;
  logic rvalid_reg;
  logic gp_fault_reg;
  logic [3:0] hit_vec_reg;
  logic brk_hit_reg;
  logic [2:0] eff_sel;
  logic sel_valid;
  logic is_status_ctrl;
  logic gp_cond;
  logic wr_ok;
  logic [63:0] wdata_eff;
  logic [63:0] rd_val;
  logic [3:0] hit_comb;
  logic [3:0] enable_vec;

  // ---------------------------------------------------------------
  // selector decode, aliases follow status/control without extensions
  // ---------------------------------------------------------------
  always_comb
  begin
    eff_sel = MOVE_I.sel;
    sel_valid = 1'b1;
    if ((MOVE_I.sel == SEL_ALIAS_STATUS) || (MOVE_I.sel == SEL_ALIAS_CTRL))
    begin
      eff_sel = MOVE_I.sel | SEL_ALIAS_OFFSET;
      sel_valid = !DEBUG_EXT_I;
    end
  end

  assign is_status_ctrl = (eff_sel == SEL_STATUS) || (eff_sel == SEL_CTRL);
  // reserved upper half of status/control must be zero in 64-bit mode
  assign gp_cond = MOVE_I.wr && sel_valid && MODE64_I && is_status_ctrl
                   && (MOVE_I.wdata[63:32] != UPPER_ZERO);
  assign wr_ok = MOVE_I.wr && sel_valid && !gp_cond;
  // upper half filled with zeros outside 64-bit mode
  assign wdata_eff = MODE64_I ? MOVE_I.wdata : {UPPER_ZERO, MOVE_I.wdata[31:0]};

  // ---------------------------------------------------------------
  // breakpoint address registers, all 64 bits, no range check
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
      bp_addr_reg <= {NUM_BP{ADDR_RESET}};
    else if (wr_ok && (eff_sel <= SEL_ADDR_3))
      bp_addr_reg[eff_sel[1:0]] <= wdata_eff;
  end

  // control register
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
      debug_control_reg <= CTRL_RESET;
    else if (wr_ok && (eff_sel == SEL_CTRL))
      debug_control_reg <= wdata_eff;
  end

  // status register: condition bits set even when not enabled, set wins
  always_comb
  begin
    status_next = debug_status_reg;
    if (wr_ok && (eff_sel == SEL_STATUS))
      status_next = wdata_eff;
    if (ACC_I.valid)
      status_next[3:0] = status_next[3:0] | hit_comb;
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
      debug_status_reg <= STATUS_RESET;
    else
      debug_status_reg <= status_next;
  end

  // ---------------------------------------------------------------
  // register read path
  // ---------------------------------------------------------------
  always_comb
  begin
    case (eff_sel)
      SEL_STATUS: rd_val = debug_status_reg;
      SEL_CTRL: rd_val = debug_control_reg;
      default: rd_val = (eff_sel <= SEL_ADDR_3) ? bp_addr_reg[eff_sel[1:0]] : ADDR_RESET;
    endcase
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      rdata_reg <= ADDR_RESET;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= MOVE_I.rd && sel_valid;
      if (MOVE_I.rd && sel_valid)
        rdata_reg <= MODE64_I ? rd_val : {UPPER_ZERO, rd_val[31:0]};
    end
  end

  // general protection fault pulse, write is dropped
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
      gp_fault_reg <= 1'b0;
    else
      gp_fault_reg <= gp_cond;
  end

  // ---------------------------------------------------------------
  // four comparators in parallel
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_BP; g++)
    begin : gen_cmp
      bkm_range_cmp u_cmp (
        .bp_addr_i(bp_addr_reg[g]),
        .access_type_field_i(debug_control_reg[CTRL_RW_LSB + g * CTRL_FIELD_STRIDE +: 2]),
        .range_length_field_i(debug_control_reg[CTRL_LEN_LSB + g * CTRL_FIELD_STRIDE +: 2]),
        .debug_ext_i(DEBUG_EXT_I),
        .acc_i(ACC_I),
        .hit_o(hit_comb[g])
      );
      assign enable_vec[g] = |debug_control_reg[g * CTRL_ENABLE_STRIDE +: 2];
    end
  endgenerate

  // hit vector and enabled hit, one cycle after the access
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      hit_vec_reg <= 4'h0;
      brk_hit_reg <= 1'b0;
    end
    else
    begin
      hit_vec_reg <= ACC_I.valid ? hit_comb : 4'h0;
      brk_hit_reg <= ACC_I.valid && ((hit_comb & enable_vec) != 4'h0);
    end
  end

  assign RDATA_O = rdata_reg;
  assign RVALID_O = rvalid_reg;
  assign GP_FAULT_O = gp_fault_reg;
  assign HIT_VEC_O = hit_vec_reg;
  assign BRK_ENABLED_HIT_O = brk_hit_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  logic [1:0] rw0;
  logic [1:0] len0;
  logic [1:0] rw1;
  logic [1:0] len1;
  logic [1:0] rw2;
  // field views of the first three breakpoints for the checks
  assign rw0 = debug_control_reg[CTRL_RW_LSB +: 2];
  assign len0 = debug_control_reg[CTRL_LEN_LSB +: 2];
  assign rw1 = debug_control_reg[CTRL_RW_LSB + CTRL_FIELD_STRIDE +: 2];
  assign len1 = debug_control_reg[CTRL_LEN_LSB + CTRL_FIELD_STRIDE +: 2];
  assign rw2 = debug_control_reg[CTRL_RW_LSB + 2 * CTRL_FIELD_STRIDE +: 2];

  sequence s_bad_upper_write;
    MOVE_I.wr && MODE64_I && (MOVE_I.sel == SEL_CTRL) && (MOVE_I.wdata[63:32] != UPPER_ZERO);
  endsequence

  sequence s_fault_and_kept;
    GP_FAULT_O && $stable(debug_control_reg);
  endsequence

  a_gp_upper_fault: assert property (s_bad_upper_write |=> s_fault_and_kept)
    else $error("reserved upper bits written without fault");

  a_gp_no_spurious: assert property (GP_FAULT_O |-> $past(MOVE_I.wr) && $past(MODE64_I))
    else $error("fault raised without a 64-bit mode write");

  a_wr_zero_upper: assert property (MOVE_I.wr && !MODE64_I && (MOVE_I.sel == 3'h0)
    |=> bp_addr_reg[0][63:32] == UPPER_ZERO)
    else $error("upper half not cleared outside 64-bit mode");

  a_wr_full_width: assert property (MOVE_I.wr && MODE64_I && (MOVE_I.sel == 3'h0)
    |=> bp_addr_reg[0] == $past(MOVE_I.wdata))
    else $error("64-bit address write not stored whole");

  // ignored alias selectors give no read pulse, so only valid reads count
  a_rd_low_half: assert property (MOVE_I.rd && sel_valid && !MODE64_I
    |=> RVALID_O && (RDATA_O[63:32] == UPPER_ZERO))
    else $error("read outside 64-bit mode returned upper half");

  a_rd_full_width: assert property (MOVE_I.rd && MODE64_I && (MOVE_I.sel == SEL_CTRL)
    |=> RDATA_O == $past(debug_control_reg))
    else $error("64-bit mode read not full width");

  a_exec_first_byte: assert property (ACC_I.valid && (ACC_I.kind == ACC_FETCH)
    && (rw0 == RW_EXEC) && (ACC_I.addr != bp_addr_reg[0]) |=> !HIT_VEC_O[0])
    else $error("code breakpoint hit off the first byte");

  // one-byte io access whose zero-extended port equals the stored address hits when extensions are on
  a_io_zero_ext: assert property (ACC_I.valid && DEBUG_EXT_I && (ACC_I.kind == ACC_IO)
    && (rw2 == RW_IO) && (ACC_I.span == SPAN_1B)
    && ({PORT_EXT_ZERO, ACC_I.addr[15:0]} == bp_addr_reg[2]) |=> HIT_VEC_O[2])
    else $error("io port breakpoint missed");

  a_len_mask_hit: assert property (ACC_I.valid && (ACC_I.kind == ACC_READ)
    && (rw1 == RW_DATA) && (len1 == LEN_8B) && (ACC_I.span == SPAN_1B)
    && (ACC_I.addr == (bp_addr_reg[1] | {SPAN_PAD, SPAN_8B})) |=> HIT_VEC_O[1])
    else $error("eight-byte range last byte not matched");

  a_read_no_write_hit: assert property (ACC_I.valid && (ACC_I.kind == ACC_READ)
    && (rw1 == RW_WRITE) |=> !HIT_VEC_O[1])
    else $error("write-only breakpoint hit on a read");

  a_hit_sets_status: assert property (HIT_VEC_O[0] |-> debug_status_reg[0])
    else $error("hit did not set its status bit");

endmodule

// [rtl/bkm_range_cmp.sv]
// one breakpoint comparator: range build and overlap test
`timescale 1ns/100ps
module bkm_range_cmp
  import bkm_pkg::*;
(
  input wire logic [63:0] bp_addr_i,
  input wire logic [1:0] access_type_field_i,
  input wire logic [1:0] range_length_field_i,
  input wire logic debug_ext_i,
  input wire bkm_pkg::bkm_access_t acc_i,
  output logic hit_o
);

  logic [2:0] bp_span;
  logic [63:0] bp_lo;
  logic [63:0] bp_hi;
  logic [63:0] acc_lo;
  logic [63:0] acc_hi;
  logic overlap;

  // length decode into last-byte offset
  always_comb
  begin
    case (range_length_field_i)
      LEN_1B: bp_span = SPAN_1B;
      LEN_2B: bp_span = SPAN_2B;
      LEN_4B: bp_span = SPAN_4B;
      LEN_8B: bp_span = SPAN_8B;
      default: bp_span = SPAN_1B;
    endcase
  end

  // aligned range from the stored address, low bits masked
  assign bp_lo = bp_addr_i & ~{SPAN_PAD, bp_span};
  assign bp_hi = bp_lo | {SPAN_PAD, bp_span};

  // io ports compare zero-extended, memory uses full address
  assign acc_lo = (acc_i.kind == ACC_IO) ? {PORT_EXT_ZERO, acc_i.addr[15:0]} : acc_i.addr;
  assign acc_hi = acc_lo + {SPAN_PAD, acc_i.span};

  // any touched byte inside the range
  assign overlap = (acc_lo <= bp_hi) && (acc_hi >= bp_lo);

  // access type qualification
  always_comb
  begin
    case (access_type_field_i)
      RW_EXEC: hit_o = (acc_i.kind == ACC_FETCH) && (acc_i.addr == bp_addr_i);
      RW_WRITE: hit_o = (acc_i.kind == ACC_WRITE) && overlap;
      RW_IO: hit_o = debug_ext_i && (acc_i.kind == ACC_IO) && overlap;
      RW_DATA: hit_o = ((acc_i.kind == ACC_READ) || (acc_i.kind == ACC_WRITE)) && overlap;
      default: hit_o = 1'b0;
    endcase
  end

endmodule

// [sim/bkm_core_model.sv]
// model of the core fetch, load/store and io units presenting accesses
`timescale 1ns/100ps
module bkm_core_model
  import bkm_pkg::*;
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire bkm_pkg::bkm_access_t req_i,
  output bkm_pkg::bkm_access_t acc_o
);
  logic [63:0] last_reg = 64'h0;
  // remember the last address so an idle bus never repeats it
  always_ff @(posedge clk_i)
  begin
    if (go_i)
    begin
      last_reg <= req_i.addr;
    end
  end
  // request held whole while go is high, scrambled fields otherwise
  always_comb
  begin
    acc_o = go_i ? req_i : '{1'b0, ACC_IO, ~last_reg, 3'h7};
  end
endmodule

// [sim/tb.sv]
// self-checking bench for the breakpoint range matcher
`timescale 1ns/100ps
module tb;
  import bkm_pkg::*;
  typedef struct packed {
    bkm_kind_t k;
    logic [23:0] a;
    logic [2:0] s;
    logic [3:0] h;
  } bkm_row_t;
  // accesses against the four example ranges, with expected hits
  localparam bkm_row_t ROWS [17] = '{
    '{ACC_READ, 24'hA0001, 3'h0, 4'h1}, '{ACC_READ, 24'hA0001, 3'h1, 4'h1},
    '{ACC_WRITE, 24'hA0002, 3'h0, 4'h2}, '{ACC_WRITE, 24'hA0002, 3'h1, 4'h2},
    '{ACC_READ, 24'hB0001, 3'h3, 4'h4}, '{ACC_READ, 24'hB0002, 3'h0, 4'h4},
    '{ACC_WRITE, 24'hB0002, 3'h1, 4'h4}, '{ACC_WRITE, 24'hC0000, 3'h3, 4'h8},
    '{ACC_WRITE, 24'hC0001, 3'h1, 4'h8}, '{ACC_WRITE, 24'hC0003, 3'h0, 4'h8},
    '{ACC_READ, 24'hA0000, 3'h0, 4'h0}, '{ACC_READ, 24'hA0002, 3'h0, 4'h0},
    '{ACC_READ, 24'hA0003, 3'h3, 4'h0}, '{ACC_WRITE, 24'hB0000, 3'h1, 4'h0},
    '{ACC_READ, 24'hC0000, 3'h1, 4'h0}, '{ACC_WRITE, 24'hC0004, 3'h3, 4'h0},
    '{ACC_FETCH, 24'hA0001, 3'h0, 4'h0}};
  logic clk;
  logic rst;
  logic mode64;
  logic dbg_ext;
  logic go;
  bkm_move_t mv;
  bkm_access_t req;
  bkm_access_t acc;
  logic [63:0] rdata;
  logic rvalid;
  logic gp;
  logic [3:0] hit;
  logic brk;
  logic [3:0] en;
  int err_count;
  int comparisons;

  bkm_core_model i_core (.clk_i(clk), .go_i(go), .req_i(req), .acc_o(acc));
  bkm_matcher i_dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .MODE64_I(mode64),
    .DEBUG_EXT_I(dbg_ext), .MOVE_I(mv), .ACC_I(acc), .RDATA_O(rdata), .RVALID_O(rvalid),
    .GP_FAULT_O(gp), .HIT_VEC_O(hit), .BRK_ENABLED_HIT_O(brk));

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // register write, then the fault pulse one cycle later
  task automatic wr(input logic [2:0] sel, input logic [63:0] d, input logic f);
    mv = '{1'b1, 1'b0, sel, d};
    @(negedge clk);
    mv = '0;
    chk("fault", 64'(f), 64'(gp));
    @(negedge clk);
  endtask
  task automatic rd(input logic [2:0] sel, input logic [63:0] exp);
    mv = '{1'b0, 1'b1, sel, 64'h0};
    @(negedge clk);
    mv = '0;
    chk("rvalid", 64'h1, 64'(rvalid));
    chk("rdata", exp, rdata);
    @(negedge clk);
  endtask
  // one access; go stays up so accesses run back to back
  task automatic ac(input bkm_kind_t k, input logic [63:0] a, input logic [2:0] s,
    input logic [3:0] h);
    req = '{1'b1, k, a, s};
    go = 1'b1;
    @(negedge clk);
    chk("hit", 64'(h), 64'(hit));
    chk("brk", 64'(|(h & en)), 64'(brk));
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // watchdog, far beyond the roughly 120 cycles of the run
  initial
  begin
    #500000;
    err_count++;
    end_of_test();
  end
  initial
  begin
    rst = 1'b1;
    mode64 = 1'b0;
    dbg_ext = 1'b0;
    go = 1'b0;
    mv = '0;
    req = '0;
    en = 4'h0;
    err_count = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("idle outputs", 64'h0, {60'h0, hit & 4'hF} | {63'h0, brk | gp | rvalid});
    for (int i = 0; i < 8; i++) rd(3'(i), 64'h0);
    // aligned example ranges
    wr(3'h0, 64'hA0001, 1'b0);
    wr(3'h1, 64'hA0002, 1'b0);
    wr(3'h2, 64'hB0002, 1'b0);
    wr(3'h3, 64'hC0000, 1'b0);
    wr(SEL_CTRL, 64'hD713_0000, 1'b0);
    rd(3'h5, 64'hD713_0000);
    foreach (ROWS[i]) ac(ROWS[i].k, 64'(ROWS[i].a), ROWS[i].s, ROWS[i].h);
    go = 1'b0;
    @(negedge clk);
    chk("hit idle", 64'h0, 64'(hit));
    rd(SEL_STATUS, 64'hF);
    // local enable of range 0 only
    wr(SEL_CTRL, 64'hD713_0001, 1'b0);
    en = 4'h1;
    ac(ACC_READ, 64'hA0001, 3'h0, 4'h1);
    ac(ACC_WRITE, 64'hC0000, 3'h0, 4'h8);
    go = 1'b0;
    en = 4'h0;
    // unaligned stored address is masked by the length
    wr(3'h3, 64'hC0002, 1'b0);
    ac(ACC_WRITE, 64'hC0000, 3'h0, 4'h8);
    go = 1'b0;
    rd(3'h3, 64'hC0002);
    // code range: one-byte length, first byte only
    wr(SEL_CTRL, 64'hD710_0000, 1'b0);
    wr(3'h0, 64'h5000, 1'b0);
    ac(ACC_FETCH, 64'h5000, 3'h0, 4'h1);
    ac(ACC_FETCH, 64'h4FFF, 3'h3, 4'h0);
    ac(ACC_READ, 64'h5000, 3'h0, 4'h0);
    go = 1'b0;
    // io range with extensions on, then off
    dbg_ext = 1'b1;
    wr(SEL_CTRL, 64'hD610_0000, 1'b0);
    wr(3'h2, 64'h80, 1'b0);
    ac(ACC_IO, 64'hFFFF_FFFF_FFFF_0081, 3'h0, 4'h4);
    ac(ACC_IO, 64'hABCD_0000_0000_0080, 3'h0, 4'h4);
    ac(ACC_IO, 64'h82, 3'h0, 4'h0);
    ac(ACC_READ, 64'h80, 3'h0, 4'h0);
    dbg_ext = 1'b0;
    ac(ACC_IO, 64'h80, 3'h0, 4'h0);
    go = 1'b0;
    // eight-byte range outside 64-bit mode
    wr(SEL_CTRL, 64'hD6B0_0000, 1'b0);
    wr(3'h1, 64'h1000, 1'b0);
    ac(ACC_READ, 64'h1007, 3'h0, 4'h2);
    ac(ACC_WRITE, 64'h0FFC, 3'h3, 4'h0);
    ac(ACC_READ, 64'h1008, 3'h0, 4'h0);
    go = 1'b0;
    // register widths per mode
    wr(3'h0, 64'hAAAA_BBBB_1234_5678, 1'b0);
    mode64 = 1'b1;
    rd(3'h0, 64'h1234_5678);
    wr(3'h0, 64'hAAAA_BBBB_1234_5678, 1'b0);
    rd(3'h0, 64'hAAAA_BBBB_1234_5678);
    wr(SEL_CTRL, 64'h1_0000_0000, 1'b1);
    rd(SEL_CTRL, 64'hD6B0_0000);
    wr(SEL_STATUS, 64'h8000_0000_0000_0000, 1'b1);
    mode64 = 1'b0;
    rd(3'h0, 64'h1234_5678);
    wr(SEL_CTRL, 64'hFFFF_FFFF_0000_0000, 1'b0);
    rd(SEL_CTRL, 64'h0);
    // unaligned two-byte operand watched by two one-byte ranges
    wr(SEL_CTRL, 64'h3300_0000, 1'b0);
    wr(3'h2, 64'h2003, 1'b0);
    wr(3'h3, 64'h2004, 1'b0);
    ac(ACC_READ, 64'h2003, 3'h1, 4'hC);
    ac(ACC_READ, 64'h2002, 3'h0, 4'h0);
    ac(ACC_WRITE, 64'h2005, 3'h0, 4'h0);
    go = 1'b0;
    // reset in mid-run clears every matcher register
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk("reset outputs", 64'h0, {60'h0, hit} | {63'h0, brk | gp | rvalid});
    rd(3'h2, 64'h0);
    rd(SEL_STATUS, 64'h0);
    end_of_test();
  end
endmodule
